/* File: rtl/dcp_pins.sv */
// Pin driver stage with three-state enables
`timescale 1ns/10ps
module dcp_pins import dcp_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Internal levels
	input wire logic off_n,
	input wire logic hold_ack,
	input wire logic xf,
	input wire logic [2:0] sel_n,
	input wire logic strb_n,
	// Pin levels and enables, low enable drives
	output logic xf_o,
	output logic xf_oe_n,
	output logic [2:0] sel_o,
	output logic sel_oe_n,
	output logic strb_o,
	output logic strb_oe_n
);
	logic xf_next;
	logic xfoe_next;
	logic [2:0] sel_next;
	logic seloe_next;
	logic strb_next;
	logic strboe_next;
	always_comb
	begin
		xf_next = ce ? xf : xf_o;
		xfoe_next = ce ? ~off_n : xf_oe_n;
		sel_next = ce ? sel_n : sel_o;
		seloe_next = ce ? (~off_n | hold_ack) : sel_oe_n;
		strb_next = ce ? strb_n : strb_o;
		strboe_next = ce ? (~off_n | hold_ack) : strb_oe_n;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			xf_o <= 1'b1;
			xf_oe_n <= 1'b0;
			sel_o <= 3'h7;
			sel_oe_n <= 1'b0;
			strb_o <= 1'b1;
			strb_oe_n <= 1'b0;
		end
		else
		begin
			xf_o <= xf_next;
			xf_oe_n <= xfoe_next;
			sel_o <= sel_next;
			sel_oe_n <= seloe_next;
			strb_o <= strb_next;
			strb_oe_n <= strboe_next;
		end
	end
endmodule // dcp_pins

/* File: rtl/dcp_pkg.sv */
// Constants for the control-pin block
package dcp_pkg;
	// Bus offsets
	localparam logic [11:0] DCP_OFF_CTRL = 12'h000;
	localparam logic [11:0] DCP_OFF_STAT = 12'h004;
	localparam logic [11:0] DCP_OFF_PC = 12'h008;
	localparam logic [11:0] DCP_OFF_NMIVEC = 12'h00c;
	localparam logic [11:0] DCP_OFF_CMD = 12'h010;
	localparam logic [11:0] DCP_OFF_ACC = 12'h014;
	// Control fields
	localparam int DCP_CTRL_RUN = 0;
	localparam int DCP_CTRL_GIM = 1;
	localparam int DCP_CTRL_PMSTW = 2;
	localparam int DCP_CTRL_PMSTV = 3;
	localparam int DCP_CTRL_BHOLD = 4;
	localparam int DCP_CTRL_IMR_LO = 8;
	// Command fields
	localparam int DCP_CMD_SETXF = 0;
	localparam int DCP_CMD_CLRXF = 1;
	localparam int DCP_CMD_LDST1 = 2;
	localparam int DCP_CMD_ST1XF = 3;
	localparam int DCP_CMD_COND = 4;
	localparam int DCP_CMD_XCI = 5;
	// Access fields
	localparam int DCP_ACC_GO = 0;
	localparam int DCP_ACC_SP_LO = 1;
	localparam logic [1:0] DCP_SP_DATA = 2'h0;
	localparam logic [1:0] DCP_SP_PROG = 2'h1;
	localparam logic [1:0] DCP_SP_IO = 2'h2;
	// Reset values
	localparam logic [15:0] DCP_RESET_VECTOR = 16'hff80;
	localparam logic [15:0] DCP_NMI_VECTOR_DEF = 16'hff88;
	localparam logic [15:0] DCP_ROM_BASE = 16'hc000;
	localparam logic [15:0] DCP_IMR_RESET = 16'h0000;
	// Access length in cycles
	localparam logic [2:0] DCP_ACC_CYCLES = 3'h3;
	localparam logic [2:0] DCP_ACC_ZERO = 3'h0;
	// Pipeline phase
	typedef enum logic [2:0]
	{
		DCP_PH_IDLE = 3'b001,
		DCP_PH_DEC = 3'b010,
		DCP_PH_READ = 3'b100
	} dcp_phase_t;
endpackage

/* File: rtl/dcp_sync.sv */
// Two-flop synchroniser for one pin
`timescale 1ns/10ps
module dcp_sync import dcp_pkg::*;
#(
	parameter logic INIT = 1'b1
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Pin and synced level
	input wire logic d,
	output logic q
);
	logic s1_reg;
	logic s1_next;
	logic s2_next;
	always_comb
	begin
		s1_next = ce ? d : s1_reg;
		s2_next = ce ? s1_reg : q;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_reg <= INIT;
			q <= INIT;
		end
		else
		begin
			s1_reg <= s1_next;
			q <= s2_next;
		end
	end
endmodule // dcp_sync

/* File: rtl/dcp_top.sv */
// Control-pin logic of the signal processor core
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module dcp_top import dcp_pkg::*;
(
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Asynchronous pins
	input wire logic core_reset_n,
	input wire logic nmi_n,
	input wire logic boot_map_select,
	input wire logic branch_condition_in_n,
	input wire logic hold_req_n,
	input wire logic off_n,
	// Status outputs
	output logic hold_ack_n,
	output logic bus_holder_en,
	output logic rom_mapped,
	output logic [15:0] pc_out,
	// Three-state pins
	output logic external_flag_out,
	output logic external_flag_oe_n,
	output logic data_space_select_n,
	output logic program_space_select_n,
	output logic io_space_select_n,
	output logic space_select_oe_n,
	output logic memory_strobe_n,
	output logic memory_strobe_oe_n
);
	logic rst_s;
	logic nmi_s;
	logic bmap_s;
	logic bio_s;
	logic hold_s;
	logic off_s;
	logic [2:0] sel_n;
	logic [2:0] sel_pin;
	dcp_sync #(.INIT(1'b0)) u_rst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(core_reset_n), .q(rst_s));
	dcp_sync #(.INIT(1'b1)) u_nmi (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(nmi_n), .q(nmi_s));
	dcp_sync #(.INIT(1'b1)) u_bmap (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(boot_map_select), .q(bmap_s));
	dcp_sync #(.INIT(1'b1)) u_bio (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(branch_condition_in_n), .q(bio_s));
	dcp_sync #(.INIT(1'b1)) u_hold (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(hold_req_n), .q(hold_s));
	dcp_sync #(.INIT(1'b1)) u_off (.hclk(hclk), .hresetn(hresetn), .ce(ce), .d(off_n), .q(off_s));

	// Bus and core state
	logic ap_wr_reg, ap_wr_next;
	logic ap_rd_reg, ap_rd_next;
	logic [11:0] ap_addr_reg, ap_addr_next;
	logic [31:0] hrdata_next;
	logic [15:0] pc_next;
	logic [15:0] nmivec_reg, nmivec_next;
	logic [15:0] imr_reg, imr_next;
	logic gim_reg, gim_next;
	logic run_reg, run_next;
	logic mpmc_reg, mpmc_next;
	logic bhold_reg, bhold_next;
	logic xf_reg, xf_next;
	logic nmi_d_reg, nmi_d_next;
	logic nmi_cnt_reg, nmi_cnt_next;
	logic hack_next, rdy_next;
	logic romm_next;
	dcp_phase_t ph_reg, ph_next;
	logic ph_xc_reg, ph_xc_next;
	logic cond_exec_reg, cond_exec_next;
	logic cond_done_reg, cond_done_next;
	logic [2:0] acc_cnt_reg, acc_cnt_next;
	logic [1:0] acc_sp_reg, acc_sp_next;
	logic [2:0] sel_next;
	logic strb_reg, strb_next;

	function automatic logic [31:0] rd_mux(input logic [11:0] a);
		case (a)
			DCP_OFF_CTRL: rd_mux = {8'h0, imr_reg, 3'h0, bhold_reg, mpmc_reg, 1'b0, gim_reg, run_reg};
			DCP_OFF_STAT: rd_mux = {24'h0, cond_done_reg, cond_exec_reg, nmi_cnt_reg, hold_ack_n, xf_reg,
				(acc_cnt_reg != DCP_ACC_ZERO), mpmc_reg, rst_s};
			DCP_OFF_PC: rd_mux = {16'h0, pc_out};
			DCP_OFF_NMIVEC: rd_mux = {16'h0, nmivec_reg};
			default: rd_mux = 32'h0;
		endcase
	endfunction

	always_comb
	begin
		ap_wr_next = ap_wr_reg;
		ap_rd_next = ap_rd_reg;
		ap_addr_next = ap_addr_reg;
		hrdata_next = hrdata;
		pc_next = pc_out;
		nmivec_next = nmivec_reg;
		imr_next = imr_reg;
		gim_next = gim_reg;
		run_next = run_reg;
		mpmc_next = mpmc_reg;
		bhold_next = bhold_reg;
		xf_next = xf_reg;
		nmi_d_next = nmi_d_reg;
		nmi_cnt_next = nmi_cnt_reg;
		hack_next = hold_ack_n;
		rdy_next = hreadyout;
		ph_next = ph_reg;
		ph_xc_next = ph_xc_reg;
		cond_exec_next = cond_exec_reg;
		cond_done_next = cond_done_reg;
		acc_cnt_next = acc_cnt_reg;
		acc_sp_next = acc_sp_reg;
		if (ce)
		begin
			// Address phase capture
			ap_wr_next = hsel && hready && htrans[1] && hwrite;
			ap_rd_next = hsel && hready && htrans[1] && !hwrite;
			// One wait state so read data stands when hready rises
			rdy_next = !ap_rd_next;
			if (hsel && hready && htrans[1])
				ap_addr_next = haddr[11:0];
			if (ap_rd_reg)
				hrdata_next = rd_mux(ap_addr_reg);
			if (ap_wr_reg)
			begin
				unique case (ap_addr_reg)
					DCP_OFF_CTRL:
					begin
						run_next = hwdata[DCP_CTRL_RUN];
						gim_next = hwdata[DCP_CTRL_GIM];
						bhold_next = hwdata[DCP_CTRL_BHOLD];
						imr_next = hwdata[DCP_CTRL_IMR_LO +: 16];
						if (hwdata[DCP_CTRL_PMSTW])
							mpmc_next = hwdata[DCP_CTRL_PMSTV];
					end
					DCP_OFF_NMIVEC: nmivec_next = hwdata[15:0];
					DCP_OFF_CMD:
					begin
						if (hwdata[DCP_CMD_SETXF])
							xf_next = 1'b1;
						else if (hwdata[DCP_CMD_CLRXF])
							xf_next = 1'b0;
						else if (hwdata[DCP_CMD_LDST1])
							xf_next = hwdata[DCP_CMD_ST1XF];
						if (hwdata[DCP_CMD_COND] && ph_reg == DCP_PH_IDLE)
						begin
							ph_next = DCP_PH_DEC;
							ph_xc_next = hwdata[DCP_CMD_XCI];
							cond_done_next = 1'b0;
						end
					end
					DCP_OFF_ACC:
						if (hwdata[DCP_ACC_GO] && acc_cnt_reg == DCP_ACC_ZERO && hold_ack_n)
						begin
							acc_cnt_next = DCP_ACC_CYCLES;
							acc_sp_next = hwdata[DCP_ACC_SP_LO +: 2];
						end
					default: ;
				endcase
			end
			unique case (ph_reg)
				DCP_PH_IDLE: ;
				DCP_PH_DEC:
				begin
					ph_next = DCP_PH_READ;
					if (ph_xc_reg)
						cond_exec_next = !bio_s;
				end
				DCP_PH_READ:
				begin
					ph_next = DCP_PH_IDLE;
					cond_done_next = 1'b1;
					if (!ph_xc_reg)
						cond_exec_next = !bio_s;
				end
			endcase
			if (acc_cnt_reg == DCP_ACC_ZERO && acc_cnt_next == DCP_ACC_ZERO)
				hack_next = hold_s;
			if (acc_cnt_reg != DCP_ACC_ZERO)
				acc_cnt_next = acc_cnt_reg - 3'h1;
			nmi_d_next = nmi_s;
			if (run_reg)
				pc_next = pc_out + 16'h1;
			if (nmi_d_reg && !nmi_s)
			begin
				pc_next = nmivec_reg;
				nmi_cnt_next = 1'b1;
			end
			if (!rst_s)
			begin
				pc_next = DCP_RESET_VECTOR;
				mpmc_next = bmap_s;
				xf_next = 1'b1;
				run_next = 1'b1;
				acc_cnt_next = DCP_ACC_ZERO;
				ph_next = DCP_PH_IDLE;
			end
		end
	end

	always_comb
	begin
		romm_next = !mpmc_reg;
		sel_next = 3'h7;
		strb_next = 1'b1;
		if (acc_cnt_reg != DCP_ACC_ZERO)
		begin
			sel_next[acc_sp_reg] = 1'b0;
			strb_next = (acc_sp_reg == DCP_SP_IO);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_reg <= 1'b0;
			ap_rd_reg <= 1'b0;
			ap_addr_reg <= 12'h000;
			hrdata <= 32'h0;
			pc_out <= DCP_RESET_VECTOR;
			nmivec_reg <= DCP_NMI_VECTOR_DEF;
			imr_reg <= DCP_IMR_RESET;
			gim_reg <= 1'b1;
			run_reg <= 1'b0;
			mpmc_reg <= 1'b1;
			bhold_reg <= 1'b0;
			xf_reg <= 1'b1;
			nmi_d_reg <= 1'b1;
			nmi_cnt_reg <= 1'b0;
			hold_ack_n <= 1'b1;
			ph_reg <= DCP_PH_IDLE;
			ph_xc_reg <= 1'b0;
			cond_exec_reg <= 1'b0;
			cond_done_reg <= 1'b0;
			acc_cnt_reg <= DCP_ACC_ZERO;
			acc_sp_reg <= DCP_SP_DATA;
			rom_mapped <= 1'b0;
			bus_holder_en <= 1'b0;
			sel_n <= 3'h7;
			strb_reg <= 1'b1;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			ap_wr_reg <= ap_wr_next;
			ap_rd_reg <= ap_rd_next;
			ap_addr_reg <= ap_addr_next;
			hrdata <= hrdata_next;
			pc_out <= pc_next;
			nmivec_reg <= nmivec_next;
			imr_reg <= imr_next;
			gim_reg <= gim_next;
			run_reg <= run_next;
			mpmc_reg <= mpmc_next;
			bhold_reg <= bhold_next;
			xf_reg <= xf_next;
			nmi_d_reg <= nmi_d_next;
			nmi_cnt_reg <= nmi_cnt_next;
			hold_ack_n <= hack_next;
			ph_reg <= ph_next;
			ph_xc_reg <= ph_xc_next;
			cond_exec_reg <= cond_exec_next;
			cond_done_reg <= cond_done_next;
			acc_cnt_reg <= acc_cnt_next;
			acc_sp_reg <= acc_sp_next;
			rom_mapped <= ce ? romm_next : rom_mapped;
			bus_holder_en <= ce ? bhold_reg : bus_holder_en;
			sel_n <= ce ? sel_next : sel_n;
			strb_reg <= ce ? strb_next : strb_reg;
			hreadyout <= rdy_next;
			hresp <= 1'b0;
		end
	end

	dcp_pins u_pins
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.off_n(off_s),
		.hold_ack(~hold_ack_n),
		.xf(xf_reg),
		.sel_n(sel_n),
		.strb_n(strb_reg),
		.xf_o(external_flag_out),
		.xf_oe_n(external_flag_oe_n),
		.sel_o(sel_pin),
		.sel_oe_n(space_select_oe_n),
		.strb_o(memory_strobe_n),
		.strb_oe_n(memory_strobe_oe_n)
	);
	assign data_space_select_n = sel_pin[0];
	assign program_space_select_n = sel_pin[1];
	assign io_space_select_n = sel_pin[2];
endmodule // dcp_top

/* File: sim/dcp_checker.sv */
// Port-level assertions for the control-pin block
`timescale 1ns/10ps
module dcp_checker import dcp_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pins in
	input wire logic core_reset_n,
	input wire logic nmi_n,
	input wire logic off_n,
	// Pins out
	input wire logic hold_ack_n,
	input wire logic [15:0] pc_out,
	input wire logic external_flag_out,
	input wire logic external_flag_oe_n,
	input wire logic data_space_select_n,
	input wire logic program_space_select_n,
	input wire logic io_space_select_n,
	input wire logic space_select_oe_n,
	input wire logic memory_strobe_n,
	input wire logic memory_strobe_oe_n
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [2:0] sel;
	assign sel = {io_space_select_n, program_space_select_n, data_space_select_n};
	property p_rst_pc; !core_reset_n [*5] |-> pc_out == DCP_RESET_VECTOR; endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("pc not held in core reset");
	property p_rst_flag; !core_reset_n [*5] |-> external_flag_out; endproperty
	a_rst_flag: assert property (p_rst_flag) else $error("flag not high in reset");
	property p_nmi; $fell(nmi_n) && core_reset_n |-> ##[3:8] pc_out == DCP_NMI_VECTOR_DEF; endproperty
	a_nmi: assert property (p_nmi) else $error("no trap to vector");
	property p_off_flag; !off_n [*5] |-> external_flag_oe_n; endproperty
	a_off_flag: assert property (p_off_flag) else $error("flag driven while disabled");
	property p_off_sel; !off_n [*5] |-> space_select_oe_n && memory_strobe_oe_n; endproperty
	a_off_sel: assert property (p_off_sel) else $error("selects driven while disabled");
	property p_hold; !hold_ack_n [*3] |-> space_select_oe_n && memory_strobe_oe_n; endproperty
	a_hold: assert property (p_hold) else $error("selects driven in hold");
	property p_one_sel; $countones(~sel) <= 1; endproperty
	a_one_sel: assert property (p_one_sel) else $error("two selects low");
	property p_sel_len; $fell(&sel) |-> (!(&sel)) [*3] ##1 (&sel); endproperty
	a_sel_len: assert property (p_sel_len) else $error("select low length");
	property p_strb; !memory_strobe_n |-> io_space_select_n && !(data_space_select_n && program_space_select_n); endproperty
	a_strb: assert property (p_strb) else $error("strobe without memory access");
	c_strb: cover property ($fell(memory_strobe_n));
	c_hold: cover property (!hold_ack_n);
	c_nmi: cover property ($fell(nmi_n) && core_reset_n);
endmodule // dcp_checker

/* File: sim/dcp_ext_mem.sv */
// External memory and bus requester model
`timescale 1ns/10ps
module dcp_ext_mem import dcp_pkg::*;
(
	// Clock
	input wire logic hclk,
	// Core bus control
	input wire logic data_space_select_n,
	input wire logic program_space_select_n,
	input wire logic io_space_select_n,
	input wire logic memory_strobe_n,
	input wire logic space_select_oe_n,
	input wire logic memory_strobe_oe_n,
	// Bench control and view
	input wire logic hold_want,
	output logic hold_req_n,
	output logic [1:0] last_sp,
	output logic [3:0] strb_cnt
);
	initial hold_req_n = 1'b1;
	initial last_sp = 2'h3;
	initial strb_cnt = 4'h0;
	always @(posedge hclk)
	begin
		hold_req_n <= !hold_want;
		// Floating selects read as pulled high
		if (!space_select_oe_n && !data_space_select_n) last_sp <= DCP_SP_DATA;
		if (!space_select_oe_n && !program_space_select_n) last_sp <= DCP_SP_PROG;
		if (!space_select_oe_n && !io_space_select_n) last_sp <= DCP_SP_IO;
		if (!memory_strobe_oe_n && !memory_strobe_n) strb_cnt <= strb_cnt + 4'h1;
	end
endmodule // dcp_ext_mem

/* File: sim/dcp_top_tb.sv */
// Self-checking bench for the control-pin block
`timescale 1ns/10ps
module dcp_top_tb import dcp_pkg::*;;
	logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b1, hwrite = 1'b0, hold_want = 1'b0;
	logic core_reset_n = 1'b0, nmi_n = 1'b1, boot_map_select = 1'b0, branch_condition_in_n = 1'b1, off_n = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic hready, hreadyout, hresp, hold_req_n, hold_ack_n, bus_holder_en, rom_mapped;
	logic external_flag_out, external_flag_oe_n, space_select_oe_n, memory_strobe_n, memory_strobe_oe_n;
	logic data_space_select_n, program_space_select_n, io_space_select_n;
	logic [15:0] pc_out;
	logic [1:0] last_sp;
	logic [3:0] strb_cnt;
	logic [3:0] corner [5] = '{4'h1, 4'h2, 4'hc, 4'h4, 4'h3};
	int bad_count = 0, num_checks = 0, cyc = 0;
	assign hready = hreadyout;
	dcp_top i_dut
	(
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.core_reset_n(core_reset_n), .nmi_n(nmi_n), .boot_map_select(boot_map_select),
		.branch_condition_in_n(branch_condition_in_n), .hold_req_n(hold_req_n), .off_n(off_n),
		.hold_ack_n(hold_ack_n), .bus_holder_en(bus_holder_en), .rom_mapped(rom_mapped), .pc_out(pc_out),
		.external_flag_out(external_flag_out), .external_flag_oe_n(external_flag_oe_n),
		.data_space_select_n(data_space_select_n), .program_space_select_n(program_space_select_n),
		.io_space_select_n(io_space_select_n), .space_select_oe_n(space_select_oe_n),
		.memory_strobe_n(memory_strobe_n), .memory_strobe_oe_n(memory_strobe_oe_n)
	);
	dcp_ext_mem i_mem
	(
		.hclk(hclk), .data_space_select_n(data_space_select_n), .program_space_select_n(program_space_select_n),
		.io_space_select_n(io_space_select_n), .memory_strobe_n(memory_strobe_n),
		.space_select_oe_n(space_select_oe_n), .memory_strobe_oe_n(memory_strobe_oe_n),
		.hold_want(hold_want), .hold_req_n(hold_req_n), .last_sp(last_sp), .strb_cnt(strb_cnt)
	);
	always #2.5 hclk = ~hclk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	function automatic logic flag_exp(input logic cur, input logic [3:0] c);
		if (c[0]) return 1'b1;
		if (c[1]) return 1'b0;
		if (c[2]) return c[3];
		return cur;
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			print_verdict();
		end
	end
	initial
	begin
		logic [31:0] r;
		logic [3:0] c;
		logic [3:0] p;
		logic f;
		logic g;
		void'($urandom(32'hda4f));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pc", DCP_RESET_VECTOR, pc_out);
		chk("pins", 4'hf, {external_flag_out, io_space_select_n, program_space_select_n, data_space_select_n});
		for (int b = 0; b < 2; b++)
		begin
			core_reset_n <= 1'b0;
			boot_map_select <= b[0];
			repeat (6) @(posedge hclk);
			core_reset_n <= 1'b1;
			for (int i = 0; i < 12 && pc_out === DCP_RESET_VECTOR; i++) @(posedge hclk);
			chk("pc start", 32'hff81, pc_out);
			chk("rom", !b[0], rom_mapped);
			boot_map_select <= !b[0];
			repeat (6) @(posedge hclk);
			chk("rom kept", !b[0], rom_mapped);
			bus(DCP_OFF_CTRL, 1'b1, 32'h5 | ({31'h0, !b[0]} << DCP_CTRL_PMSTV), r);
			repeat (2) @(posedge hclk);
			chk("rom override", b[0], rom_mapped);
		end
		bus(DCP_OFF_CTRL, 1'b1, 32'h00ffff03, r);
		nmi_n <= 1'b0;
		repeat (4) @(posedge hclk);
		nmi_n <= 1'b1;
		repeat (4) @(posedge hclk);
		bus(DCP_OFF_STAT, 1'b0, 32'h0, r);
		chk("nmi seen", 1, r[5]);
		f = 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			c = (i < 5) ? corner[i] : 4'($urandom);
			if (c[1]) c[2] = 1'b0;
			f = flag_exp(f, c);
			bus(DCP_OFF_CMD, 1'b1, {28'h0, c}, r);
			repeat (2) @(posedge hclk);
			chk("flag", f, external_flag_out);
		end
		for (int i = 0; i < 6; i++)
		begin
			f = 1'($urandom);
			g = 1'($urandom);
			branch_condition_in_n <= f;
			repeat (4) @(posedge hclk);
			// Pin moves between decode and read phase samples
			fork
				bus(DCP_OFF_CMD, 1'b1, 32'h10 | (32'(i % 2) << DCP_CMD_XCI), r);
				begin
					@(posedge hclk);
					branch_condition_in_n <= g;
				end
			join
			repeat (4) @(posedge hclk);
			bus(DCP_OFF_STAT, 1'b0, 32'h0, r);
			chk("cond", {1'b1, (i % 2 == 1) ? !f : !g}, r[7:6]);
		end
		for (int s = 0; s < 3; s++)
		begin
			p = strb_cnt;
			bus(DCP_OFF_ACC, 1'b1, 32'h1 | (32'(s) << DCP_ACC_SP_LO), r);
			repeat (6) @(posedge hclk);
			chk("space", s, last_sp);
			chk("strobe", (s == 2) ? 0 : 3, strb_cnt - p);
		end
		off_n <= 1'b0;
		repeat (6) @(posedge hclk);
		chk("off", 3'h7, {external_flag_oe_n, space_select_oe_n, memory_strobe_oe_n});
		off_n <= 1'b1;
		hold_want <= 1'b1;
		repeat (8) @(posedge hclk);
		chk("hold", 3'h3, {hold_ack_n, space_select_oe_n, memory_strobe_oe_n});
		hold_want <= 1'b0;
		repeat (8) @(posedge hclk);
		chk("unhold", 4'h8, {hold_ack_n, external_flag_oe_n, space_select_oe_n, memory_strobe_oe_n});
		bus(DCP_OFF_CTRL, 1'b1, 32'h11, r);
		repeat (2) @(posedge hclk);
		chk("holder", 1, bus_holder_en);
		bus(12'h100, 1'b0, 32'h0, r);
		chk("unmapped", 0, r);
		chk("hresp", 0, hresp);
		print_verdict();
	end
endmodule // dcp_top_tb
bind dcp_top dcp_checker i_chk
(
	.hclk(hclk), .hresetn(hresetn), .core_reset_n(core_reset_n), .nmi_n(nmi_n), .off_n(off_n),
	.hold_ack_n(hold_ack_n), .pc_out(pc_out), .external_flag_out(external_flag_out),
	.external_flag_oe_n(external_flag_oe_n), .data_space_select_n(data_space_select_n),
	.program_space_select_n(program_space_select_n), .io_space_select_n(io_space_select_n),
	.space_select_oe_n(space_select_oe_n), .memory_strobe_n(memory_strobe_n), .memory_strobe_oe_n(memory_strobe_oe_n)
);
